// >>> design/ser_status_top.sv
// Status byte, service request and event registers
`timescale 1ns/1ps
// Behaviour
// - Event bits stay set until read-cleared, clear-status or their own instrument clear; no software write.
// - Status bit 3 is the enabled OR of instrument events.
// - Status bit 4 follows message-available of the output buffer.
// - Status bit 5 is the enabled OR of standard events.
// - Status bit 6 is master summary of enabled status bits.
// - Mask bit 6 unwritable; status bits 0-2 and 7 read zero.
// - Serial poll returns byte with request flag in bit 6, then clears flag.
// - Master summary becoming one raises request flag and service request line.
// - Serial poll leaves other status bits alone.
// - Clear-status clears status byte, summary, flag and line; keeps message-available.
// - Status query clears nothing; status byte clear after reset.
// - Service request mask clears at reset and on zero write.
// - Standard events: complete, device error, exec error, command error, power-on.
// - Standard events clear at reset, clear-status and query read.
// - Standard mask clears at reset, loads written value.
// - Instrument events latch comparator, count, ringing, limiter, stop and trigger.
// - Halt bit and active bit follow the output state.
// - Buffer-full bit follows the buffer full level.
// - Calibration and ramp done bits set on done, clear on start.
// - Step bit sets on step done, clears on step start, pause or start.
// - Measure bit sets on done, clears on start or data read.
// - Instrument events clear at reset, clear-status and query read.
// - Instrument mask clears at reset, loads written value.
module ser_status_top (
	input  wire logic                        i_clk_sys,
	input  wire logic                        i_reset_n,
	input  wire logic                        i_cls,
	input  wire logic                        i_serial_poll,
	input  wire logic                        i_stb_query,
	input  wire logic                        i_esr_query,
	input  wire logic                        i_dsr_query,
	input  wire logic                        i_sre_wr,
	input  wire logic [ser_pkg::STB_W-1:0]   i_sre_data,
	input  wire logic                        i_ese_wr,
	input  wire logic [ser_pkg::STANDARD_EVENT_LATCH_W-1:0]  i_ese_data,
	input  wire logic                        i_instrument_mask_write_cmd,
	input  wire logic [ser_pkg::INSTRUMENT_EVENT_LATCH_W-1:0]  i_dse_data,
	input  wire logic                        i_msg_avail,
	input  wire logic                        i_op_complete,
	input  wire logic                        i_dev_error,
	input  wire logic                        i_exec_error,
	input  wire logic                        i_cmd_error,
	input  wire logic                        i_comparator_over,
	input  wire logic                        i_comparator_pass,
	input  wire logic                        i_comparator_under,
	input  wire logic                        i_halt_state_flag,
	input  wire logic                        i_store_count_reached,
	input  wire logic                        i_ringing_detected,
	input  wire logic                        i_lower_limiter_hit,
	input  wire logic                        i_upper_limiter_hit,
	input  wire logic                        i_external_output_stop_in,
	input  wire logic                        i_external_trigger_in,
	input  wire logic                        i_buffer_full_flag,
	input  wire logic                        i_output_active_state,
	input  wire logic                        i_calibration_done,
	input  wire logic                        i_calibration_start,
	input  wire logic                        i_ramp_done,
	input  wire logic                        i_ramp_start,
	input  wire logic                        i_ramp_step_done,
	input  wire logic                        i_ramp_step_start,
	input  wire logic                        i_ramp_pause,
	input  wire logic                        i_measure_done,
	input  wire logic                        i_measure_start,
	input  wire logic                        i_measure_read,
	output logic [ser_pkg::STB_W-1:0]        o_status_byte,
	output logic                             o_srq,
	output logic [ser_pkg::STB_W-1:0]        o_poll_byte,
	output logic                             o_poll_valid,
	output logic [ser_pkg::STB_W-1:0]        o_stb_byte,
	output logic                             o_stb_valid,
	output logic [ser_pkg::STANDARD_EVENT_LATCH_W-1:0]       o_esr_byte,
	output logic                             o_esr_valid,
	output logic [ser_pkg::INSTRUMENT_EVENT_LATCH_W-1:0]       o_dsr_word,
	output logic                             o_dsr_valid,
	output logic [ser_pkg::STB_W-1:0]        o_sre_mask,
	output logic [ser_pkg::STANDARD_EVENT_LATCH_W-1:0]       o_ese_mask,
	output logic [ser_pkg::INSTRUMENT_EVENT_LATCH_W-1:0]       o_dse_mask
);
	ser_latch_if #(.W(ser_pkg::STANDARD_EVENT_LATCH_W)) std_if ();
	ser_latch_if #(.W(ser_pkg::INSTRUMENT_EVENT_LATCH_W)) dev_if ();

	logic [ser_pkg::PIN_N-1:0]  pin_meta_q;
	logic [ser_pkg::PIN_N-1:0]  pin_sync_q;
	logic [ser_pkg::PIN_N-1:0]  pin_prev_q;
	logic [ser_pkg::PIN_N-1:0]  pin_edge;
	logic                       pon_pend_q;
	logic [ser_pkg::STB_W-1:0]  stb_q;
	logic [ser_pkg::STB_W-1:0]  stb_d;
	logic [ser_pkg::STB_W-1:0]  sre_q;
	logic [ser_pkg::STB_W-1:0]  sre_d;
	logic                       rqs_q;
	logic                       rqs_d;
	logic                       rqs_set;
	logic                       rqs_clr;
	logic                       mss_d;
	logic                       dsb_d;
	logic                       esb_d;
	logic [ser_pkg::STANDARD_EVENT_LATCH_W-1:0] std_set;
	logic [ser_pkg::INSTRUMENT_EVENT_LATCH_W-1:0] dev_set;
	logic [ser_pkg::INSTRUMENT_EVENT_LATCH_W-1:0] dev_clr;

	ser_event_latch #(.W(ser_pkg::STANDARD_EVENT_LATCH_W)) u_std_latch (
		.i_clk_sys (i_clk_sys),
		.i_reset_n (i_reset_n),
		.bus       (std_if.latch)
	);

	ser_event_latch #(.W(ser_pkg::INSTRUMENT_EVENT_LATCH_W)) u_dev_latch (
		.i_clk_sys (i_clk_sys),
		.i_reset_n (i_reset_n),
		.bus       (dev_if.latch)
	);

	// Pin synchronisers and rising edges
	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
			pin_prev_q <= '0;
		end
		else
		begin
			pin_meta_q <= {i_external_trigger_in, i_external_output_stop_in};
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
		end
	end

	assign pin_edge = pin_sync_q & ~pin_prev_q;

	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
			pon_pend_q <= 1'b1;
		else
			pon_pend_q <= 1'b0;
	end

	always_comb
	begin
		std_set                   = '0;
		std_set[ser_pkg::SES_OPC] = i_op_complete;
		std_set[ser_pkg::SES_DDE] = i_dev_error;
		std_set[ser_pkg::SES_EXE] = i_exec_error;
		std_set[ser_pkg::SES_CME] = i_cmd_error;
		std_set[ser_pkg::SES_PON] = pon_pend_q;
	end

	assign std_if.set       = std_set & ser_pkg::SES_USED;
	assign std_if.clr       = '0;
	assign std_if.clr_all   = i_cls | i_esr_query;
	assign std_if.mask_wr   = i_ese_wr;
	assign std_if.mask_data = i_ese_data;

	always_comb
	begin
		dev_set                          = '0;
		dev_set[ser_pkg::DES_CMP_OVER]   = i_comparator_over;
		dev_set[ser_pkg::DES_CMP_PASS]   = i_comparator_pass;
		dev_set[ser_pkg::DES_CMP_UNDER]  = i_comparator_under;
		dev_set[ser_pkg::DES_STORE_CNT]  = i_store_count_reached;
		dev_set[ser_pkg::DES_RINGING]    = i_ringing_detected;
		dev_set[ser_pkg::DES_LIM_LOW]    = i_lower_limiter_hit;
		dev_set[ser_pkg::DES_LIM_HIGH]   = i_upper_limiter_hit;
		dev_set[ser_pkg::DES_EXT_STOP]   = pin_edge[ser_pkg::PIN_STOP];
		dev_set[ser_pkg::DES_EXT_TRIG]   = pin_edge[ser_pkg::PIN_TRIG];
		dev_set[ser_pkg::DES_HALT]       = i_halt_state_flag;
		dev_set[ser_pkg::DES_OUT_ACTIVE] = i_output_active_state;
		dev_set[ser_pkg::DES_BUF_FULL]   = i_buffer_full_flag;
		dev_set[ser_pkg::DES_CAL_DONE]   = i_calibration_done;
		dev_set[ser_pkg::DES_RAMP_DONE]  = i_ramp_done;
		dev_set[ser_pkg::DES_STEP_DONE]  = i_ramp_step_done;
		dev_set[ser_pkg::DES_MEAS_DONE]  = i_measure_done;
	end

	always_comb
	begin
		dev_clr                          = '0;
		dev_clr[ser_pkg::DES_HALT]       = ~i_halt_state_flag;
		dev_clr[ser_pkg::DES_OUT_ACTIVE] = ~i_output_active_state;
		dev_clr[ser_pkg::DES_BUF_FULL]   = ~i_buffer_full_flag;
		dev_clr[ser_pkg::DES_CAL_DONE]   = i_calibration_start;
		dev_clr[ser_pkg::DES_RAMP_DONE]  = i_ramp_start;
		dev_clr[ser_pkg::DES_STEP_DONE]  = i_ramp_step_start | i_ramp_pause | i_ramp_start;
		dev_clr[ser_pkg::DES_MEAS_DONE]  = i_measure_start | i_measure_read;
	end

	assign dev_if.set       = dev_set;
	assign dev_if.clr       = dev_clr;
	assign dev_if.clr_all   = i_cls | i_dsr_query;
	assign dev_if.mask_wr   = i_instrument_mask_write_cmd;
	assign dev_if.mask_data = i_dse_data;

	assign sre_d = i_sre_wr ? (i_sre_data & ser_pkg::SRE_WMASK) : sre_q;

	assign dsb_d = dev_if.summary & ~(i_cls | i_dsr_query);
	assign esb_d = std_if.summary & ~(i_cls | i_esr_query);

	always_comb
	begin
		stb_d                   = ser_pkg::STB_RST;
		stb_d[ser_pkg::STB_DSB] = dsb_d;
		stb_d[ser_pkg::STB_MAV] = i_msg_avail;
		stb_d[ser_pkg::STB_ESB] = esb_d;
		mss_d                   = |(stb_d & sre_d);
		stb_d[ser_pkg::STB_MSS] = mss_d;
	end

	assign rqs_set = mss_d & ~stb_q[ser_pkg::STB_MSS];
	assign rqs_clr = i_serial_poll | i_cls;
	assign rqs_d   = rqs_set | (rqs_q & ~rqs_clr);

	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			stb_q <= ser_pkg::STB_RST;
			sre_q <= ser_pkg::STB_RST;
			rqs_q <= 1'b0;
		end
		else
		begin
			stb_q <= stb_d;
			sre_q <= sre_d;
			rqs_q <= rqs_d;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_poll_byte  <= ser_pkg::STB_RST;
			o_poll_valid <= 1'b0;
			o_stb_byte   <= ser_pkg::STB_RST;
			o_stb_valid  <= 1'b0;
			o_esr_byte   <= ser_pkg::STANDARD_EVENT_LATCH_RST;
			o_esr_valid  <= 1'b0;
			o_dsr_word   <= ser_pkg::INSTRUMENT_EVENT_LATCH_RST;
			o_dsr_valid  <= 1'b0;
		end
		else
		begin
			o_poll_valid <= i_serial_poll;
			o_stb_valid  <= i_stb_query;
			o_esr_valid  <= i_esr_query;
			o_dsr_valid  <= i_dsr_query;
			if (i_serial_poll)
				o_poll_byte <= {stb_q[7], rqs_q, stb_q[5:0]};
			if (i_stb_query)
				o_stb_byte <= stb_q;
			if (i_esr_query)
				o_esr_byte <= std_if.q;
			if (i_dsr_query)
				o_dsr_word <= dev_if.q;
		end
	end

	assign o_status_byte = stb_q;
	assign o_srq         = rqs_q;
	assign o_sre_mask    = sre_q;
	assign o_ese_mask    = std_if.mask;
	assign o_dse_mask    = dev_if.mask;

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_reset_n);

	sequence seq_poll_plain;
		i_serial_poll && !rqs_set;
	endsequence

	sequence seq_cls_plain;
		i_cls && !rqs_set;
	endsequence

	sequence seq_dev_seen;
		dev_if.summary && !i_cls && !i_dsr_query;
	endsequence

	AST_DSB_SUMMARY: assert property (seq_dev_seen |=> o_status_byte[3])
		else $error("device summary bit missing");

	AST_MAV_FOLLOW: assert property (##1 o_status_byte[4] == $past(i_msg_avail))
		else $error("message available not following buffer");

	AST_ESB_CLEAR: assert property (i_esr_query |=> !o_status_byte[5])
		else $error("standard summary kept after read");

	AST_MSS_CALC: assert property ((|(stb_q[5:0] & sre_q[5:0])) |-> stb_q[6])
		else $error("master summary not set");

	AST_FIXED_ZERO: assert property (stb_q[2:0] == 3'h0 && !stb_q[7] && !sre_q[6])
		else $error("reserved status bits nonzero");

	AST_POLL_CLEAR: assert property (seq_poll_plain |=> !o_srq ##0 o_poll_valid)
		else $error("request flag survived serial poll");

	AST_POLL_BYTE: assert property (i_serial_poll |=>
		o_poll_byte == {1'b0, $past(rqs_q), $past(stb_q[5:0])})
		else $error("serial poll byte wrong");

	AST_SRQ_RISE: assert property ($rose(o_status_byte[6]) |-> o_srq)
		else $error("service request not raised");

	AST_POLL_KEEPS: assert property (i_serial_poll && i_msg_avail |=> o_status_byte[4])
		else $error("serial poll disturbed status bits");

	AST_CLS_CLEARS: assert property (seq_cls_plain |=>
		!o_srq && !o_status_byte[3] && !o_status_byte[5])
		else $error("clear-status left bits set");

	AST_STB_QUERY: assert property (i_stb_query && !i_cls |=> o_stb_valid ##0
		o_stb_byte == $past(stb_q))
		else $error("status query answer wrong");

	AST_ESR_CLEAR: assert property (i_esr_query && std_if.set == '0 |=> std_if.q == '0)
		else $error("standard events not cleared by read");

	AST_DES_CLEAR: assert property (i_cls && dev_if.set == '0 |=> dev_if.q == '0)
		else $error("instrument events not cleared");

	AST_HALT_FOLLOW: assert property (##1 dev_if.q[3] == $past(i_halt_state_flag))
		else $error("halt bit not following state");

	AST_MEAS_CLEAR: assert property (i_measure_read && !i_measure_done |=> !dev_if.q[15])
		else $error("measure bit kept after read-out");

	AST_PON_SET: assert property (pon_pend_q |=> std_if.q[7] [*2])
		else $error("power-on bit not latched");
endmodule : ser_status_top

// >>> include/ser_pkg.sv
// Constants for the status and event reporting block
package ser_pkg;
	localparam int STB_W  = 8;
	localparam int STANDARD_EVENT_LATCH_W = 8;
	localparam int INSTRUMENT_EVENT_LATCH_W = 16;

	// Status byte bit positions
	localparam int STB_DSB = 3;
	localparam int STB_MAV = 4;
	localparam int STB_ESB = 5;
	localparam int STB_MSS = 6;

	// Standard event bit positions
	localparam int SES_OPC = 0;
	localparam int SES_DDE = 3;
	localparam int SES_EXE = 4;
	localparam int SES_CME = 5;
	localparam int SES_PON = 7;
	localparam logic [STANDARD_EVENT_LATCH_W-1:0] SES_USED = 8'hB9;

	// Instrument event bit positions
	localparam int DES_CMP_OVER   = 0;
	localparam int DES_CMP_PASS   = 1;
	localparam int DES_CMP_UNDER  = 2;
	localparam int DES_HALT       = 3;
	localparam int DES_STORE_CNT  = 4;
	localparam int DES_RINGING    = 5;
	localparam int DES_LIM_LOW    = 6;
	localparam int DES_LIM_HIGH   = 7;
	localparam int DES_EXT_STOP   = 8;
	localparam int DES_EXT_TRIG   = 9;
	localparam int DES_BUF_FULL   = 10;
	localparam int DES_OUT_ACTIVE = 11;
	localparam int DES_CAL_DONE   = 12;
	localparam int DES_RAMP_DONE  = 13;
	localparam int DES_STEP_DONE  = 14;
	localparam int DES_MEAS_DONE  = 15;

	// Service request mask: bit 6 not storable
	localparam logic [STB_W-1:0] SRE_WMASK = 8'hBF;

	// Reset values
	localparam logic [STB_W-1:0]  STB_RST  = 8'h00;
	localparam logic [STANDARD_EVENT_LATCH_W-1:0] STANDARD_EVENT_LATCH_RST = 8'h00;
	localparam logic [INSTRUMENT_EVENT_LATCH_W-1:0] INSTRUMENT_EVENT_LATCH_RST = 16'h0000;

	// Synchronised pin indices
	localparam int PIN_N    = 2;
	localparam int PIN_STOP = 0;
	localparam int PIN_TRIG = 1;
endpackage : ser_pkg

// >>> include/ser_latch_if.sv
// Carrier between the top and one event latch
`timescale 1ns/1ps
interface ser_latch_if #(
	parameter int W = 8
);
	logic [W-1:0] set;
	logic [W-1:0] clr;
	logic         clr_all;
	logic         mask_wr;
	logic [W-1:0] mask_data;
	logic [W-1:0] q;
	logic [W-1:0] mask;
	logic         summary;

	modport owner (
		output set,
		output clr,
		output clr_all,
		output mask_wr,
		output mask_data,
		input  q,
		input  mask,
		input  summary
	);

	modport latch (
		input  set,
		input  clr,
		input  clr_all,
		input  mask_wr,
		input  mask_data,
		output q,
		output mask,
		output summary
	);
endinterface : ser_latch_if

// >>> design/ser_event_latch.sv
// Event register with its enable mask and summary
`timescale 1ns/1ps
module ser_event_latch #(
	parameter int W = 8
) (
	input  wire logic i_clk_sys,
	input  wire logic i_reset_n,
	ser_latch_if.latch bus
);
	logic [W-1:0] q_q;
	logic [W-1:0] q_d;
	logic [W-1:0] mask_q;
	logic [W-1:0] mask_d;
	logic [W-1:0] keep;

	assign keep   = ~bus.clr & {W{~bus.clr_all}};
	assign q_d    = (q_q & keep) | bus.set;
	assign mask_d = bus.mask_wr ? bus.mask_data : mask_q;

	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			q_q    <= '0;
			mask_q <= '0;
		end
		else
		begin
			q_q    <= q_d;
			mask_q <= mask_d;
		end
	end

	assign bus.q       = q_q;
	assign bus.mask    = mask_q;
	assign bus.summary = |(q_q & mask_q);

	AST_LATCH_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(!bus.clr_all && bus.clr == '0) |=> ((q_q & $past(q_q)) == $past(q_q)))
		else $error("event bit lost without a clear");
endmodule : ser_event_latch

// >>> tb/ser_host_model.sv
// Remote controller model issuing queries, polls and mask writes
`timescale 1ns/1ps
module ser_host_model (
	input  wire logic        i_clk_sys,
	input  wire logic [7:0]  i_poll_byte,
	input  wire logic        i_poll_valid,
	input  wire logic [7:0]  i_stb_byte,
	input  wire logic        i_stb_valid,
	input  wire logic [7:0]  i_esr_byte,
	input  wire logic        i_esr_valid,
	input  wire logic [15:0] i_dsr_word,
	input  wire logic        i_dsr_valid,
	output logic [3:0]       o_query,
	output logic [2:0]       o_wr,
	output logic [7:0]       o_sre_data,
	output logic [7:0]       o_ese_data,
	output logic [15:0]      o_dse_data
);
	initial
	begin
		o_query    = 4'h0;
		o_wr       = 3'h0;
		o_sre_data = 8'h00;
		o_ese_data = 8'h00;
		o_dse_data = 16'h0000;
	end

	// Query kinds 0 poll, 1 status, 2 standard, 3 instrument
	task ask(input int k, output logic [15:0] v, output logic ok);
		@(posedge i_clk_sys);
		#1;
		o_query[k] = 1'b1;
		@(posedge i_clk_sys);
		#1;
		o_query = 4'h0;
		case (k)
			0: begin v = {8'h00, i_poll_byte}; ok = i_poll_valid; end
			1: begin v = {8'h00, i_stb_byte}; ok = i_stb_valid; end
			2: begin v = {8'h00, i_esr_byte}; ok = i_esr_valid; end
			default: begin v = i_dsr_word; ok = i_dsr_valid; end
		endcase
	endtask : ask

	// Mask writes 0 service, 1 standard, 2 instrument; data inverted after release
	task wr(input int k, input logic [15:0] d);
		@(posedge i_clk_sys);
		#1;
		o_sre_data = d[7:0];
		o_ese_data = d[7:0];
		o_dse_data = d;
		o_wr[k]    = 1'b1;
		@(posedge i_clk_sys);
		#1;
		o_wr       = 3'h0;
		o_sre_data = ~d[7:0];
		o_ese_data = ~d[7:0];
		o_dse_data = ~d;
	endtask : wr
endmodule : ser_host_model

// >>> tb/tb.sv
// Self-checking bench for the status reporting block
`timescale 1ns/1ps
module tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [23:0] p = 24'h000000;
	logic [3:0]  lv = 4'h0;
	logic [3:0]  qry;
	logic [2:0]  wrs;
	logic [7:0]  sre_d, ese_d, stb, poll_b, stb_b, esr_b, sre_m, ese_m;
	logic [15:0] dse_d, dsr_w, dse_m;
	logic        srq, poll_v, stb_v, esr_v, dsr_v;
	int          bad_count = 0;
	int          check_count = 0;

	always #50 clk = ~clk;

	ser_status_top dut_u (
		.i_clk_sys(clk), .i_reset_n(rst_n), .i_cls(p[21]),
		.i_serial_poll(qry[0]), .i_stb_query(qry[1]), .i_esr_query(qry[2]),
		.i_dsr_query(qry[3]), .i_sre_wr(wrs[0]), .i_sre_data(sre_d),
		.i_ese_wr(wrs[1]), .i_ese_data(ese_d), .i_instrument_mask_write_cmd(wrs[2]),
		.i_dse_data(dse_d), .i_msg_avail(lv[3]), .i_op_complete(p[0]),
		.i_dev_error(p[1]), .i_exec_error(p[2]), .i_cmd_error(p[3]),
		.i_comparator_over(p[4]), .i_comparator_pass(p[5]), .i_comparator_under(p[6]),
		.i_halt_state_flag(lv[0]), .i_store_count_reached(p[7]),
		.i_ringing_detected(p[8]), .i_lower_limiter_hit(p[9]),
		.i_upper_limiter_hit(p[10]), .i_external_output_stop_in(p[22]),
		.i_external_trigger_in(p[23]), .i_buffer_full_flag(lv[1]),
		.i_output_active_state(lv[2]), .i_calibration_done(p[11]),
		.i_calibration_start(p[12]), .i_ramp_done(p[13]), .i_ramp_start(p[14]),
		.i_ramp_step_done(p[15]), .i_ramp_step_start(p[16]), .i_ramp_pause(p[17]),
		.i_measure_done(p[18]), .i_measure_start(p[19]), .i_measure_read(p[20]),
		.o_status_byte(stb), .o_srq(srq), .o_poll_byte(poll_b), .o_poll_valid(poll_v),
		.o_stb_byte(stb_b), .o_stb_valid(stb_v), .o_esr_byte(esr_b),
		.o_esr_valid(esr_v), .o_dsr_word(dsr_w), .o_dsr_valid(dsr_v),
		.o_sre_mask(sre_m), .o_ese_mask(ese_m), .o_dse_mask(dse_m)
	);

	ser_host_model host_u (
		.i_clk_sys(clk), .i_poll_byte(poll_b), .i_poll_valid(poll_v),
		.i_stb_byte(stb_b), .i_stb_valid(stb_v), .i_esr_byte(esr_b),
		.i_esr_valid(esr_v), .i_dsr_word(dsr_w), .i_dsr_valid(dsr_v),
		.o_query(qry), .o_wr(wrs), .o_sre_data(sre_d), .o_ese_data(ese_d),
		.o_dse_data(dse_d)
	);

	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask : chk

	task q(input int k, input string n, input logic [15:0] e);
		logic [15:0] v;
		logic        ok;
		host_u.ask(k, v, ok);
		chk({n, "_valid"}, 16'h0001, {15'h0000, ok});
		chk(n, e, v);
	endtask : q

	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task pulse(input logic [23:0] m);
		@(posedge clk);
		#1;
		p = m;
		@(posedge clk);
		#1;
		p = 24'h000000;
		cyc(4);
	endtask : pulse

	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict

	initial
	begin
		#2000000;
		bad_count++;
		print_verdict();
	end

	initial
	begin
		cyc(16);
		rst_n = 1'b1;
		cyc(3);
		q(2, "esr_pon", 16'h0080);
		q(2, "esr_reread", 16'h0000);
		chk("masks_rst", 16'h0000, {sre_m, ese_m});
		chk("dse_rst", 16'h0000, dse_m);
		chk("stb_rst", 16'h0000, {8'h00, stb});
		host_u.wr(1, 16'h00FF);
		chk("ese_mask", 16'h00FF, {8'h00, ese_m});
		pulse(24'h00000F);
		chk("stb_esb", 16'h0020, {8'h00, stb});
		q(2, "esr_events", 16'h0039);
		cyc(2);
		chk("stb_esb_off", 16'h0000, {8'h00, stb});
		host_u.wr(2, 16'hFFFF);
		chk("dse_mask", 16'hFFFF, dse_m);
		lv = 4'h7;
		pulse(24'hC4AFF0);
		q(3, "dsr_all", 16'hFFFF);
		pulse(24'h04A800);
		pulse(24'h135000);
		q(3, "dsr_start_clr", 16'h0C08);
		pulse(24'h048000);
		pulse(24'h090000);
		q(3, "dsr_start_clr2", 16'h0C08);
		lv = 4'h8;
		host_u.wr(0, 16'h00FF);
		chk("sre_mask", 16'h00BF, {8'h00, sre_m});
		host_u.wr(0, 16'h0008);
		pulse(24'h040000);
		chk("stb_mss", 16'h0058, {8'h00, stb});
		chk("srq_on", 16'h0001, {15'h0000, srq});
		q(0, "poll", 16'h0058);
		chk("srq_poll", 16'h0000, {15'h0000, srq});
		chk("stb_poll", 16'h0058, {8'h00, stb});
		q(1, "stb_query", 16'h0058);
		chk("stb_after_q", 16'h0058, {8'h00, stb});
		pulse(24'h200000);
		chk("stb_cls", 16'h0010, {8'h00, stb});
		chk("srq_cls", 16'h0000, {15'h0000, srq});
		q(3, "dsr_cls", 16'h0000);
		host_u.wr(0, 16'h0000);
		host_u.wr(1, 16'h0000);
		host_u.wr(2, 16'h0000);
		chk("masks_zero", 16'h0000, {sre_m, ese_m});
		chk("dse_zero", 16'h0000, dse_m);
		lv = 4'h0;
		cyc(3);
		chk("stb_mav_off", 16'h0000, {8'h00, stb});
		print_verdict();
	end
endmodule : tb
